// >>> logic/capability_word_builder.sv
// Builds the two constant capability words from build parameters.
// Assumes parameters are fixed at elaboration; no clock needed.
`timescale 1ns/1ps
`default_nettype none
module capability_word_builder #(
   parameter logic [7:0] PROC_TYPE = core_capability_pkg::PROC_TYPE_DEF,
   parameter logic [3:0] PROC_REV = core_capability_pkg::PROC_REV_DEF,
   parameter logic [2:0] ARCH_REV = core_capability_pkg::ARCH_REV_DEF,
   parameter bit HAS_PROT = 1'b1,
   parameter bit HAS_FPU = 1'b0,
   parameter bit HAS_DEBUG = 1'b1,
   parameter logic [5:0] PROT_ENTRIES = core_capability_pkg::PROT_ENTRY_DEF
) (
   output logic [core_capability_pkg::DATA_W-1:0] wordA,
   output logic [core_capability_pkg::DATA_W-1:0] wordB
);
   import core_capability_pkg::*;
   // Field assembly of word a; reserved bits stay zero
   always_comb begin
      wordA = '0;
      wordA[PROC_TYPE_LSB +: 8] = PROC_TYPE;
      wordA[PROC_REV_LSB +: 4] = PROC_REV;
      wordA[ARCH_TYPE_LSB +: 3] = ARCH_TYPE_BASE;
      wordA[ARCH_REV_LSB +: 3] = ARCH_REV;
      wordA[MEM_MGMT_LSB +: 3] = HAS_PROT ? MEM_MGMT_PROT : MEM_MGMT_NONE;
      wordA[FPU_BIT] = HAS_FPU;
      wordA[BYTECODE_BIT] = 1'b0;
      wordA[PERF_BIT] = 1'b0;
      wordA[DEBUG_BIT] = HAS_DEBUG;
      wordA[SIMD_BIT] = 1'b0;
      wordA[DSP_BIT] = 1'b1;
      wordA[RMW_BIT] = 1'b1;
   end
   // Word b holds only the entry count
   always_comb begin
      wordB = '0;
      wordB[PROT_ENTRY_LSB +: 6] = HAS_PROT ? PROT_ENTRIES : 6'h00;
   end
endmodule
`default_nettype wire

// >>> logic/core_capability_pkg.sv
// Package for the core capability word block: offsets, field layout, build values.
// Assumes one 32-bit AXI4-Lite slave; both words are read-only constants.
package core_capability_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   // Byte offsets of the two words
   localparam logic [ADDR_W-1:0] OFFS_WORD_A = 4'h0;
   localparam logic [ADDR_W-1:0] OFFS_WORD_B = 4'h4;
   // Field positions of word a
   localparam int PROC_TYPE_LSB = 24;
   localparam int PROC_REV_LSB = 16;
   localparam int ARCH_TYPE_LSB = 13;
   localparam int ARCH_REV_LSB = 10;
   localparam int MEM_MGMT_LSB = 7;
   localparam int FPU_BIT = 6;
   localparam int BYTECODE_BIT = 5;
   localparam int PERF_BIT = 4;
   localparam int DEBUG_BIT = 3;
   localparam int SIMD_BIT = 2;
   localparam int DSP_BIT = 1;
   localparam int RMW_BIT = 0;
   // Field position of word b
   localparam int PROT_ENTRY_LSB = 20;
   // Field codes
   localparam logic [2:0] MEM_MGMT_NONE = 3'h0;
   localparam logic [2:0] MEM_MGMT_PROT = 3'h3;
   localparam logic [2:0] ARCH_TYPE_BASE = 3'h0;
   // Build defaults; type code and revision are arbitrary values
   localparam logic [7:0] PROC_TYPE_DEF = 8'h5a;
   localparam logic [3:0] PROC_REV_DEF = 4'h1;
   localparam logic [2:0] ARCH_REV_DEF = 3'h2;
   localparam logic [5:0] PROT_ENTRY_DEF = 6'h08;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/cpu_capability_id_registers.sv
// AXI4-Lite slave presenting the two read-only capability words.
// Word a sits at byte offset 0x0 and word b at 0x4; other offsets read zero with an error response.
// Every write is refused with an error response and changes nothing.
// A read is answered one cycle after its address is taken.
// Assumes a single clock and a master that keeps at most one read and one write open.
// Assumes all inputs synchronous to core_clk; the words depend on build parameters only.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpu_capability_id_registers #(
   parameter logic [7:0] PROC_TYPE = core_capability_pkg::PROC_TYPE_DEF,
   parameter logic [3:0] PROC_REV = core_capability_pkg::PROC_REV_DEF,
   parameter logic [2:0] ARCH_REV = core_capability_pkg::ARCH_REV_DEF,
   parameter bit HAS_PROT = 1'b1,
   parameter bit HAS_FPU = 1'b0,
   parameter bit HAS_DEBUG = 1'b1,
   parameter logic [5:0] PROT_ENTRIES = core_capability_pkg::PROT_ENTRY_DEF
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [core_capability_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [core_capability_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [core_capability_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [core_capability_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import core_capability_pkg::*;

   // Constant words from the builder
   logic [DATA_W-1:0] wordA;
   logic [DATA_W-1:0] wordB;

   // Write halves already taken, and takes at this edge
   logic awTaken_r;
   logic wTaken_r;
   logic awTakeNow;
   logic wTakeNow;
   logic writePaired;
   logic respTaken;

   // Read take terms and the answer decoded from the address
   logic arTakeNow;
   logic readTaken;
   logic [DATA_W-1:0] readData;
   logic [1:0] readResp;

   // Write address, data, strobes and protection bits are never read:
   // both words are constants, so a write only earns its refusal.
   // Read protection bits are ignored too; both words are public.

   // Constant words, fixed at build time
   capability_word_builder #(
      .PROC_TYPE(PROC_TYPE),
      .PROC_REV(PROC_REV),
      .ARCH_REV(ARCH_REV),
      .HAS_PROT(HAS_PROT),
      .HAS_FPU(HAS_FPU),
      .HAS_DEBUG(HAS_DEBUG),
      .PROT_ENTRIES(PROT_ENTRIES)
   ) u_builder (
      .wordA(wordA),
      .wordB(wordB)
   );

   // Handshake terms for the write side
   assign awTakeNow = s_axi_awvalid & s_axi_awready;
   assign wTakeNow = s_axi_wvalid & s_axi_wready;
   // Both halves of the write in hand, now or at an earlier edge
   assign writePaired = (awTaken_r || awTakeNow) && (wTaken_r || wTakeNow);
   // Response accepted by the master; frees the write side
   assign respTaken = s_axi_bvalid & s_axi_bready;

   // Handshake terms for the read side
   assign arTakeNow = s_axi_arvalid & s_axi_arready;
   assign readTaken = s_axi_rvalid & s_axi_rready;

   // Write address taken; cleared once the response is accepted
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         awTaken_r <= 1'b0;
      end else if (awTakeNow) begin
         awTaken_r <= 1'b1;
      end else if (respTaken) begin
         awTaken_r <= 1'b0;
      end
   end

   // Write address ready: one pulse per write, none while a response stands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
      end else if (!awTaken_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end else begin
         s_axi_awready <= 1'b0;
      end
   end

   // Write data taken; cleared once the response is accepted
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wTaken_r <= 1'b0;
      end else if (wTakeNow) begin
         wTaken_r <= 1'b1;
      end else if (respTaken) begin
         wTaken_r <= 1'b0;
      end
   end

   // Write data ready: one pulse per write, none while a response stands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b0;
      end else if (!wTaken_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end else begin
         s_axi_wready <= 1'b0;
      end
   end

   // Write response valid; stands until the master takes it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
      end else if (s_axi_bvalid) begin
         if (respTaken) begin
            s_axi_bvalid <= 1'b0;
         end
      end else if (writePaired) begin
         s_axi_bvalid <= 1'b1;
      end
   end

   // Response code; words are read-only so every write is refused
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bresp <= RESP_OKAY;
      end else if (!s_axi_bvalid && writePaired) begin
         s_axi_bresp <= RESP_SLVERR;
      end
   end

   // Read decode of the two words
   always_comb begin
      readData = '0;
      readResp = RESP_SLVERR;
      unique case (s_axi_araddr)
         OFFS_WORD_A: begin
            readData = wordA;
            readResp = RESP_OKAY;
         end
         OFFS_WORD_B: begin
            readData = wordB;
            readResp = RESP_OKAY;
         end
         default: begin
            readData = '0;
            readResp = RESP_SLVERR;
         end
      endcase
   end

   // Address ready: one pulse per read, never while an answer stands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && !arTakeNow && !s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_arready <= 1'b0;
      end
   end

   // Read valid: rises the cycle after the take, stands until accepted
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
      end else if (s_axi_rvalid) begin
         if (readTaken) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (arTakeNow) begin
         s_axi_rvalid <= 1'b1;
      end
   end

   // Read data and code, captured at the take and held while valid stands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (!s_axi_rvalid && arTakeNow) begin
         s_axi_rdata <= readData;
         s_axi_rresp <= readResp;
      end
   end
endmodule
`default_nettype wire

// >>> verif/capability_monitor.sv
// Checker for the capability word slave: handshakes and word fields.
// Assumes it is bound to the slave and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module capability_monitor #(
   parameter logic [7:0] PROC_TYPE = core_capability_pkg::PROC_TYPE_DEF,
   parameter logic [3:0] PROC_REV = core_capability_pkg::PROC_REV_DEF,
   parameter bit HAS_PROT = 1'b1,
   parameter bit HAS_FPU = 1'b0,
   parameter bit HAS_DEBUG = 1'b1,
   parameter logic [5:0] PROT_ENTRIES = core_capability_pkg::PROT_ENTRY_DEF
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [core_capability_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [core_capability_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid
);
   import core_capability_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] rdAddr_r;
   logic isA, isB;
   // Address of the read under way
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) rdAddr_r <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready) rdAddr_r <= s_axi_araddr;
   end
   assign isA = s_axi_rvalid && rdAddr_r == OFFS_WORD_A;
   assign isB = s_axi_rvalid && rdAddr_r == OFFS_WORD_B;
   chk_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   chk_type_rev: assert property (isA |-> s_axi_rdata[31:24] == PROC_TYPE
      && s_axi_rdata[19:16] == PROC_REV) else $error("type or revision wrong");
   chk_reserved_zero: assert property (isA |-> s_axi_rdata[23:20] == 4'h0)
      else $error("reserved bits set");
   chk_mem_type: assert property (isA |-> s_axi_rdata[9:7] ==
      (HAS_PROT ? MEM_MGMT_PROT : MEM_MGMT_NONE)) else $error("memory type wrong");
   chk_build_flags: assert property (isA |-> s_axi_rdata[6] == HAS_FPU
      && s_axi_rdata[3] == HAS_DEBUG) else $error("build flags wrong");
   chk_absent_flags: assert property (isA |-> s_axi_rdata[5:4] == 2'h0)
      else $error("absent feature flagged");
   chk_arch_fields: assert property (isA |-> s_axi_rdata[15:13] == ARCH_TYPE_BASE
      && s_axi_rdata[12:10] inside {[1:3]}) else $error("architecture fields wrong");
   chk_fixed_flags: assert property (isA |-> s_axi_rdata[2:0] == 3'h3)
      else $error("fixed flags wrong");
   chk_word_b: assert property (isB |-> s_axi_rdata[31:26] == 6'h0
      && s_axi_rdata[25:20] == (HAS_PROT ? PROT_ENTRIES : 6'h00)
      && s_axi_rdata[19:0] == 20'h0) else $error("word b wrong");
   chk_write_refused: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_SLVERR)
      else $error("write accepted");
   cov_read_a: cover property (isA);
   cov_read_b: cover property (isB);
   cov_write: cover property (s_axi_bvalid);
   cov_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind cpu_capability_id_registers capability_monitor #(.PROC_TYPE(PROC_TYPE),
   .PROC_REV(PROC_REV), .HAS_PROT(HAS_PROT), .HAS_FPU(HAS_FPU), .HAS_DEBUG(HAS_DEBUG),
   .PROT_ENTRIES(PROT_ENTRIES)) mon (.core_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bresp, .s_axi_bvalid);
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the capability word slave over AXI4-Lite.
// Assumes the design's default build parameters.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import core_capability_pkg::*;
   localparam logic [31:0] WA = {PROC_TYPE_DEF, 4'h0, PROC_REV_DEF, ARCH_TYPE_BASE,
      ARCH_REV_DEF, MEM_MGMT_PROT, 7'h0b};
   localparam logic [31:0] WB = {6'h0, PROT_ENTRY_DEF, 20'h0};
   // Second build: no protection unit, FPU fitted, no debug
   localparam logic [31:0] WA_ALT = {PROC_TYPE_DEF, 4'h0, PROC_REV_DEF, ARCH_TYPE_BASE,
      ARCH_REV_DEF, MEM_MGMT_NONE, 7'h43};
   localparam logic [31:0] WB_ALT = 32'h0;
   logic core_clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] rdataAlt, dAlt;
   logic v;
   int fails = 0, check_count = 0;
   cpu_capability_id_registers DUT (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   // Second build with the optional features flipped; shares the bus inputs
   cpu_capability_id_registers #(.HAS_PROT(1'b0), .HAS_FPU(1'b1), .HAS_DEBUG(1'b0)) DUT_ALT (
      .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready(),
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready(), .s_axi_rdata(rdataAlt), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);
   task automatic chk(input logic [31:0] g, e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Read one word; rready held back for stall cycles once rvalid stands
   task automatic rd(input logic [3:0] a, input int stall);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (stall == 0);
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
      if (stall > 0) begin
         repeat (stall) @(posedge core_clk);
         s_axi_rready <= 1'b1;
         @(posedge core_clk);
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      v = s_axi_rvalid;
      dAlt = rdataAlt;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a);
      bit ta, tw;
      @(posedge core_clk);
      s_axi_awaddr <= a; s_axi_wdata <= 32'hffffffff; s_axi_bready <= 1'b1;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; ta = 0; tw = 0;
      while (!(ta && tw)) begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1) begin ta = 1; s_axi_awvalid <= 1'b0; end
         if (s_axi_wready === 1'b1) begin tw = 1; s_axi_wvalid <= 1'b0; end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
      r = s_axi_bresp; s_axi_bready <= 1'b0;
   endtask
   // Both words twice, back to back, with a growing rready stall
   task automatic t_words;
      for (int i = 0; i < 4; i++) begin
         rd(i[0] ? OFFS_WORD_B : OFFS_WORD_A, i);
         chk(d, i[0] ? WB : WA);
         chk(dAlt, i[0] ? WB_ALT : WA_ALT);
         chk({31'h0, v}, 32'h1);
         chk({30'h0, r}, {30'h0, RESP_OKAY});
      end
   endtask
   // Writes refused and words unchanged
   task automatic t_write;
      for (int i = 0; i < 2; i++) begin
         wr(i[0] ? OFFS_WORD_B : OFFS_WORD_A);
         chk({30'h0, r}, {30'h0, RESP_SLVERR});
         rd(i[0] ? OFFS_WORD_B : OFFS_WORD_A, 0);
         chk(d, i[0] ? WB : WA);
      end
   endtask
   task automatic t_unmapped;
      logic [3:0] bad[3] = '{4'h8, 4'hc, 4'h2};
      foreach (bad[i]) begin
         rd(bad[i], 0);
         chk(d, 32'h0);
         chk({30'h0, r}, {30'h0, RESP_SLVERR});
      end
   endtask
   task automatic close_out;
      if (fails == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial forever #5 core_clk = ~core_clk;
   // Watchdog against a hung handshake
   initial begin
      #50000;
      fails++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk({s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid}, 0);
      t_words();
      t_write();
      t_unmapped();
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      t_words();
      close_out();
   end
endmodule
`default_nettype wire
